/* File: rtl/ibx_cfg.svh */
`ifndef IBX_CFG_SVH
`define IBX_CFG_SVH
`define IBX_OP_PTR_INC 8'ha3
`define IBX_OP_REG_INC_HI 5'h01
`define IBX_OP_GROUP_FIELD 7:3
`define IBX_REG_SEL_FIELD 2:0
`define IBX_OP_DIR_INC 8'h05
`define IBX_OP_BIT_SET 8'h20
`define IBX_OP_BIT_CLR_JMP 8'h10
`define IBX_OP_CARRY 8'h40
`define IBX_OP_NO_CARRY 8'h50
`define IBX_OP_BIT_CLEAR 8'h30
`define IBX_OP_NONZERO 8'h70
`define IBX_OP_ZERO 8'h60
`define IBX_OP_INDEXED 8'h73
`define IBX_LEN_TWO 16'h0002
`define IBX_LEN_THREE 16'h0003
`define IBX_RESET_PC 16'h0000
`endif

/* File: rtl/ibx_decode.sv */
`timescale 1ns/1ps
`include "ibx_cfg.svh"
module ibx_decode (
  // Opcode in
  input wire logic [7:0] opcode,
  // Class out
  output ibx_pkg::ibx_op_type op_class
);
  always_comb begin
    op_class = ibx_pkg::IBX_NONE;
    if (opcode[`IBX_OP_GROUP_FIELD] == `IBX_OP_REG_INC_HI) begin
      op_class = ibx_pkg::IBX_REG_INC;
    end else begin
      unique case (opcode)
        `IBX_OP_PTR_INC: op_class = ibx_pkg::IBX_PTR_INC;
        `IBX_OP_DIR_INC: op_class = ibx_pkg::IBX_DIR_INC;
        `IBX_OP_BIT_SET: op_class = ibx_pkg::IBX_BIT_SET;
        `IBX_OP_BIT_CLR_JMP: op_class = ibx_pkg::IBX_BIT_CLR_JMP;
        `IBX_OP_CARRY: op_class = ibx_pkg::IBX_CARRY;
        `IBX_OP_NO_CARRY: op_class = ibx_pkg::IBX_NO_CARRY;
        `IBX_OP_BIT_CLEAR: op_class = ibx_pkg::IBX_BIT_CLEAR;
        `IBX_OP_NONZERO: op_class = ibx_pkg::IBX_NONZERO;
        `IBX_OP_ZERO: op_class = ibx_pkg::IBX_ZERO;
        `IBX_OP_INDEXED: op_class = ibx_pkg::IBX_INDEXED;
        default: op_class = ibx_pkg::IBX_NONE;
      endcase
    end
  end
endmodule

/* File: rtl/ibx_exec.sv */
`timescale 1ns/1ps
`include "ibx_cfg.svh"
module ibx_exec (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction in
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  // Core state in
  input wire logic [7:0] accumulator,
  input wire logic carry,
  input wire logic [7:0] pointer_high,
  input wire logic [7:0] pointer_low,
  input wire logic [7:0] working_register,
  input wire logic [7:0] direct_data,
  input wire logic bit_value,
  // Handshake out
  output logic busy,
  output logic done,
  // Program counter out
  output logic pc_we,
  output logic [15:0] pc_out,
  // Pointer out
  output logic ptr_we,
  output logic [15:0] data_pointer,
  // Register out
  output logic reg_we,
  output logic [2:0] reg_sel,
  output logic [7:0] reg_data,
  // Direct memory out
  output logic dir_we,
  output logic [7:0] dir_addr,
  output logic [7:0] dir_data,
  // Bit space out
  output logic [7:0] bit_addr,
  output logic bit_we
);
  ibx_pkg::ibx_op_type op_class;
  ibx_pkg::ibx_op_type op_held;
  ibx_pkg::ibx_op_type next_op_held;
  ibx_pkg::ibx_state_type state;
  ibx_pkg::ibx_state_type next_state;
  logic next_done;
  logic next_pc_we;
  logic next_ptr_we;
  logic next_reg_we;
  logic next_dir_we;
  logic next_bit_we;
  logic [15:0] next_pc_out;
  logic [15:0] next_data_pointer;
  logic [15:0] pc_adv;
  logic [15:0] target;
  logic [15:0] pointer_in;
  logic [2:0] next_reg_sel;
  logic [7:0] next_reg_data;
  logic [7:0] next_dir_addr;
  logic [7:0] next_dir_data;
  logic [7:0] next_bit_addr;

  ibx_decode ibx_decode_inst (
    .opcode(opcode),
    .op_class(op_class)
  );

  // Offset is signed: sign-extend before the add so backward branches wrap correctly.
  function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
    rel_target = base + {{8{off[7]}}, off};
  endfunction

  // Bit-addressed branches are three bytes long and take their offset from byte three.
  function automatic logic is_bit_branch(input ibx_pkg::ibx_op_type op);
    is_bit_branch = (op == ibx_pkg::IBX_BIT_SET) || (op == ibx_pkg::IBX_BIT_CLR_JMP) ||
      (op == ibx_pkg::IBX_BIT_CLEAR);
  endfunction

  // The pointer bytes are treated as one word below.
  assign pointer_in = {pointer_high, pointer_low};

  assign busy = (state == ibx_pkg::IBX_SECOND);

  // The class is kept so that the second cycle knows which writes it owns.
  always_comb begin
    next_op_held = op_held;
    if (state == ibx_pkg::IBX_IDLE && instr_valid) begin
      next_op_held = op_class;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      op_held <= ibx_pkg::IBX_NONE;
    end else begin
      op_held <= next_op_held;
    end
  end

  always_comb begin
    next_state = ibx_pkg::IBX_IDLE;
    next_done = 1'b0;
    next_pc_we = 1'b0;
    next_ptr_we = 1'b0;
    next_reg_we = 1'b0;
    next_dir_we = 1'b0;
    next_bit_we = 1'b0;
    next_pc_out = pc_out;
    next_data_pointer = data_pointer;
    next_reg_sel = reg_sel;
    next_reg_data = reg_data;
    next_dir_addr = dir_addr;
    next_dir_data = dir_data;
    next_bit_addr = bit_addr;
    pc_adv = pc_in + `IBX_LEN_TWO;
    target = rel_target(pc_adv, byte2);
    if (is_bit_branch(op_class)) begin
      pc_adv = pc_in + `IBX_LEN_THREE;
      target = rel_target(pc_adv, byte3);
    end
    // Two-cycle instructions register their results and bit_we at the end of the first cycle and raise done and pc_we
    // at the end of the second; ptr_we is raised then only for the pointer increment.
    if (state == ibx_pkg::IBX_IDLE && instr_valid) begin
      unique case (op_class)
        ibx_pkg::IBX_REG_INC: begin
          next_reg_we = 1'b1;
          next_reg_sel = opcode[`IBX_REG_SEL_FIELD];
          next_reg_data = working_register + 8'h01;
          next_done = 1'b1;
        end
        ibx_pkg::IBX_DIR_INC: begin
          next_dir_we = 1'b1;
          next_dir_addr = byte2;
          next_dir_data = direct_data + 8'h01;
          next_done = 1'b1;
        end
        ibx_pkg::IBX_NONE: begin
          next_state = ibx_pkg::IBX_IDLE;
        end
        default: begin
          next_state = ibx_pkg::IBX_SECOND;
          next_bit_addr = byte2;
          next_pc_out = pc_adv;
          unique case (op_class)
            ibx_pkg::IBX_PTR_INC: begin
              next_data_pointer = pointer_in + 16'h0001;
            end
            ibx_pkg::IBX_INDEXED: begin
              // The sum wraps at the top of the code space; no carry is kept.
              next_pc_out = {8'h00, accumulator} + pointer_in;
            end
            ibx_pkg::IBX_BIT_SET: begin
              if (bit_value) next_pc_out = target;
            end
            ibx_pkg::IBX_BIT_CLR_JMP: begin
              if (bit_value) next_pc_out = target;
            end
            ibx_pkg::IBX_BIT_CLEAR: begin
              if (!bit_value) next_pc_out = target;
            end
            ibx_pkg::IBX_CARRY: begin
              if (carry) next_pc_out = target;
            end
            ibx_pkg::IBX_NO_CARRY: begin
              if (!carry) next_pc_out = target;
            end
            ibx_pkg::IBX_NONZERO: begin
              if (accumulator != 8'h00) next_pc_out = target;
            end
            ibx_pkg::IBX_ZERO: begin
              if (accumulator == 8'h00) next_pc_out = target;
            end
            default: begin
              next_pc_out = pc_adv;
            end
          endcase
          // The bit clear is issued in the first cycle so it lands before the branch retires.
          next_bit_we = (op_class == ibx_pkg::IBX_BIT_CLR_JMP) && bit_value;
        end
      endcase
    end else if (state == ibx_pkg::IBX_SECOND) begin
      next_done = 1'b1;
      next_pc_we = 1'b1;
      // Only the pointer increment owns the pointer; a branch must not write it back.
      next_ptr_we = (op_held == ibx_pkg::IBX_PTR_INC);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ibx_pkg::IBX_IDLE;
      done <= 1'b0;
      pc_we <= 1'b0;
      ptr_we <= 1'b0;
      reg_we <= 1'b0;
      dir_we <= 1'b0;
      bit_we <= 1'b0;
      pc_out <= `IBX_RESET_PC;
      data_pointer <= 16'h0000;
      reg_sel <= 3'h0;
      reg_data <= 8'h00;
      dir_addr <= 8'h00;
      dir_data <= 8'h00;
      bit_addr <= 8'h00;
    end else begin
      state <= next_state;
      done <= next_done;
      pc_we <= next_pc_we;
      ptr_we <= next_ptr_we;
      reg_we <= next_reg_we;
      dir_we <= next_dir_we;
      bit_we <= next_bit_we;
      pc_out <= next_pc_out;
      data_pointer <= next_data_pointer;
      reg_sel <= next_reg_sel;
      reg_data <= next_reg_data;
      dir_addr <= next_dir_addr;
      dir_data <= next_dir_data;
      bit_addr <= next_bit_addr;
    end
  end
endmodule

/* File: rtl/ibx_pkg.sv */
package ibx_pkg;
  typedef enum logic [1:0] {
    IBX_IDLE = 2'b00,
    IBX_SECOND = 2'b01
  } ibx_state_type;
  typedef enum logic [3:0] {
    IBX_NONE = 4'h0,
    IBX_PTR_INC = 4'h1,
    IBX_REG_INC = 4'h2,
    IBX_DIR_INC = 4'h3,
    IBX_BIT_SET = 4'h4,
    IBX_BIT_CLR_JMP = 4'h5,
    IBX_CARRY = 4'h6,
    IBX_NO_CARRY = 4'h7,
    IBX_BIT_CLEAR = 4'h8,
    IBX_NONZERO = 4'h9,
    IBX_ZERO = 4'ha,
    IBX_INDEXED = 4'hb
  } ibx_op_type;
endpackage

/* File: sim/ibx_exec_chk.sv */
`timescale 1ns/1ps
module ibx_exec_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction in
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  // Core state in
  input wire logic [7:0] accumulator,
  input wire logic carry,
  input wire logic [7:0] pointer_high,
  input wire logic [7:0] pointer_low,
  input wire logic [7:0] working_register,
  input wire logic [7:0] direct_data,
  input wire logic bit_value,
  // Design outputs
  input wire logic busy,
  input wire logic done,
  input wire logic pc_we,
  input wire logic [15:0] pc_out,
  input wire logic ptr_we,
  input wire logic [15:0] data_pointer,
  input wire logic reg_we,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_data,
  input wire logic dir_we,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_data,
  input wire logic [7:0] bit_addr,
  input wire logic bit_we
);
  logic tk, c2, c3;
  logic [15:0] ptr, e2, e3;
  assign tk = instr_valid && !busy;
  assign ptr = {pointer_high, pointer_low};
  assign c2 = opcode[5] ? (opcode[4] ~^ |accumulator) : (opcode[4] ^ carry);
  assign c3 = opcode[5:4] == 2'b11 ? !bit_value : bit_value;
  assign e2 = pc_in + 16'h0002 + (c2 ? {{8{byte2[7]}}, byte2} : 16'h0000);
  assign e3 = pc_in + 16'h0003 + (c3 ? {{8{byte3[7]}}, byte3} : 16'h0000);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reg_inc_a: assert property (
    tk && opcode[7:3] == 5'h01 |=> reg_we && done && reg_sel == $past(opcode[2:0])
    && reg_data == $past(working_register) + 8'h01) else $error("register increment wrong");
  dir_inc_a: assert property (
    tk && opcode == 8'h05 |=> dir_we && done && dir_addr == $past(byte2)
    && dir_data == $past(direct_data) + 8'h01) else $error("direct increment wrong");
  ptr_inc_a: assert property (
    tk && opcode == 8'ha3 |=> busy && !done ##1 ptr_we && done
    && data_pointer == $past(ptr, 2) + 16'h0001) else $error("pointer increment wrong");
  ptr_write_only_a: assert property (
    ptr_we |-> $past(tk, 2) && $past(opcode, 2) == 8'ha3)
    else $error("pointer written by another instruction");
  short_jump_a: assert property (
    tk && opcode[7:6] == 2'b01 && opcode[3:0] == 4'h0 |=> busy ##1 pc_we && done
    && pc_out == $past(e2, 2)) else $error("two-byte branch wrong");
  long_jump_a: assert property (
    tk && opcode[7:6] == 2'b00 && opcode[5:4] != 2'b00 && opcode[3:0] == 4'h0
    |=> busy ##1 pc_we && done && pc_out == $past(e3, 2)) else $error("bit branch wrong");
  clear_bit_a: assert property (
    tk && opcode == 8'h10 |=> bit_we == $past(bit_value) && bit_addr == $past(byte2))
    else $error("bit clear wrong");
  indexed_jump_a: assert property (
    tk && opcode == 8'h73 |=> busy ##1 pc_we && done
    && pc_out == $past(ptr, 2) + {8'h00, $past(accumulator, 2)}) else $error("indexed wrong");
  unknown_op_a: assert property (
    tk && opcode == 8'ha5 |=> !done && !busy) else $error("unknown opcode executed");
endmodule
bind ibx_exec ibx_exec_chk ibx_exec_chk_inst (.*);

/* File: sim/ibx_exec_tb_top.sv */
`timescale 1ns/1ps
module ibx_exec_tb_top;
  logic core_clk, rst_n, instr_valid, carry, bit_value, bw;
  logic [7:0] opcode, byte2, byte3, accumulator, pointer_high, pointer_low;
  logic [7:0] working_register, direct_data;
  logic [15:0] pc_in;
  wire logic busy, done, pc_we, ptr_we, reg_we, dir_we, bit_we;
  wire logic [2:0] reg_sel;
  wire logic [7:0] reg_data, dir_addr, dir_data, bit_addr;
  wire logic [15:0] pc_out, data_pointer;
  int n_mismatch, total_checks, cyc;
  ibx_exec ibx_exec_inst (.*);
  always #2.5 core_clk = ~core_clk;
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 1000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Valid stays high on return so that a following call is taken back to back.
  task go(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    int i;
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    instr_valid = 1'b1;
    @(negedge core_clk);
    bw = bit_we;
    for (i = 0; i < 3 && done !== 1'b1; i++) @(negedge core_clk);
    chk(done, 1'b1);
  endtask
  task rest;
    instr_valid = 1'b0;
    @(negedge core_clk);
  endtask
  task t_inc;
    working_register = 8'hff;
    go(8'h0f, 8'h00, 8'h00);
    chk({reg_we, reg_sel, reg_data}, 16'h0f00);
    working_register = 8'hbf;
    go(8'h0d, 8'h00, 8'h00);
    chk({reg_we, reg_sel, reg_data}, 16'h0dc0);
    direct_data = 8'h7f;
    go(8'h05, 8'h90, 8'h00);
    chk({dir_addr, dir_data}, 16'h9080);
    chk(dir_we, 1'b1);
    pointer_high = 8'h68;
    pointer_low = 8'hff;
    go(8'ha3, 8'h00, 8'h00);
    chk(data_pointer, 16'h6900);
    chk(ptr_we, 1'b1);
    rest;
  endtask
  task t_short;
    int i;
    pc_in = 16'h1000;
    for (i = 0; i < 8; i++) begin
      carry = i[2];
      accumulator = {7'h00, i[2]};
      go({2'b01, i[1:0], 4'h0}, 8'h80, 8'h00);
      chk(pc_out, (i[2] ^ i[1] ^ i[0]) ? 16'h0f82 : 16'h1002);
    end
    rest;
  endtask
  task t_long;
    int i;
    pc_in = 16'hfff0;
    for (i = 2; i < 8; i++) begin
      bit_value = i[0];
      go({2'b00, i[2:1], 4'h0}, 8'h2a, 8'h7f);
      chk(pc_out, ((i[2:1] == 2'b11) ^ i[0]) ? 16'h0072 : 16'hfff3);
      chk(bw, i[2:1] == 2'b01 && i[0]);
    end
    rest;
  endtask
  // The unknown opcode follows directly on the done cycle, so it must be dropped.
  task t_index;
    accumulator = 8'hff;
    pointer_high = 8'hff;
    pointer_low = 8'hff;
    go(8'h73, 8'h00, 8'h00);
    chk(pc_out, 16'h00fe);
    chk(ptr_we, 1'b0);
    opcode = 8'ha5;
    @(negedge core_clk);
    chk({busy, done}, 16'h0000);
    rest;
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    carry = 1'b0;
    bit_value = 1'b0;
    opcode = 8'h00;
    byte2 = 8'h00;
    byte3 = 8'h00;
    accumulator = 8'h00;
    pointer_high = 8'h00;
    pointer_low = 8'h00;
    working_register = 8'h00;
    direct_data = 8'h00;
    pc_in = 16'h0000;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk({13'h0000, busy, done, pc_we}, 16'h0000);
    chk(pc_out, 16'h0000);
    t_inc;
    t_short;
    t_long;
    t_index;
    finish_test;
  end
endmodule
